/* File: rgc_regs.sv */
// Control register bank for the I/O buck, peripheral buck and first linear regulator
// Assumes a plain strobe register port and pins synchronous to ref_clk_in
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
// Function
// - Pin field: 00 sequencer, 01 input one, 10 input two, 11 input thirteen.
// - I/O buck enable pin: rising enables, falling disables.
// - I/O buck voltage pin: rising picks A, falling picks B.
// - I/O buck bit 3 sequencer target, bit 0 enable.
// - Peripheral buck voltage pin: rising picks A, falling picks B.
// - Peripheral buck enable pin: rising enables, falling disables.
// - Peripheral register bit 7 switch target, bit 4 closes switch.
// - Peripheral buck bit 3 sequencer target, bit 0 enable.
// - Linear regulator voltage pin: rising picks A, falling picks B.
// - Linear regulator enable pin: rising enables, falling disables.
// - Linear regulator bit 7 sequencer target, bit 0 enable.
// - Linear regulator bit 3: 0 pull-down on while disabled, 1 pull-down off.
module rgc_regs (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // Sequencer and pins
    input wire logic seq_go_active_in,
    input wire logic seq_go_passive_in,
    input wire logic pin_one_in,
    input wire logic pin_two_in,
    input wire logic pin_thirteen_in,
    // Regulator controls
    output logic io_buck_enable_out,
    output logic io_buck_voltage_b_out,
    output logic peripheral_buck_enable_out,
    output logic peripheral_buck_voltage_b_out,
    output logic peripheral_switch_close_out,
    output logic linear_reg_first_enable_out,
    output logic linear_reg_first_voltage_b_out,
    output logic linear_reg_first_pulldown_on_out
);
    // ==========================================
    // Storage: index 0 io buck, 1 peripheral buck, 2 linear regulator
    localparam int NREG = 3;
    localparam logic [7:0] ADDRS [NREG] = '{rgc_pkg::ADDR_IO_BUCK_CONTROL,
        rgc_pkg::ADDR_PERIPHERAL_BUCK_CONTROL, rgc_pkg::ADDR_LINEAR_REG_FIRST_CONTROL};
    localparam logic [7:0] RSTS [NREG] = '{rgc_pkg::RST_IO_BUCK_CONTROL,
        rgc_pkg::RST_PERIPHERAL_BUCK_CONTROL, rgc_pkg::RST_LINEAR_REG_FIRST_CONTROL};
    localparam logic [7:0] MASKS [NREG] = '{rgc_pkg::MASK_IO_BUCK,
        rgc_pkg::MASK_PERIPHERAL_BUCK, rgc_pkg::MASK_LINEAR_REG_FIRST};
    // Enable target bit differs between bucks and the linear regulator
    localparam int TGT [NREG] = '{rgc_pkg::BIT_BUCK_TARGET, rgc_pkg::BIT_BUCK_TARGET,
        rgc_pkg::BIT_LDO_TARGET};

    logic [7:0] ctrl_r [NREG];
    logic [7:0] ctrl_nxt [NREG];
    logic [NREG-1:0] en_mode, en_rise, en_fall;
    logic [NREG-1:0] v_mode, v_rise, v_fall;
    logic [NREG-1:0] vsel_b_r;

    // ==========================================
    // Per-register logic
    for (genvar i = 0; i < NREG; i++) begin : g_reg
        rgc_pin_select u_en_sel (
            .ref_clk_in(ref_clk_in),
            .rst_b_in(rst_b_in),
            .sel_in(ctrl_r[i][rgc_pkg::FLD_EN_SEL_HI:rgc_pkg::FLD_EN_SEL_LO]),
            .pin_one_in(pin_one_in),
            .pin_two_in(pin_two_in),
            .pin_thirteen_in(pin_thirteen_in),
            .pin_mode_out(en_mode[i]),
            .rise_out(en_rise[i]),
            .fall_out(en_fall[i])
        );
        rgc_pin_select u_v_sel (
            .ref_clk_in(ref_clk_in),
            .rst_b_in(rst_b_in),
            .sel_in(ctrl_r[i][rgc_pkg::FLD_V_SEL_HI:rgc_pkg::FLD_V_SEL_LO]),
            .pin_one_in(pin_one_in),
            .pin_two_in(pin_two_in),
            .pin_thirteen_in(pin_thirteen_in),
            .pin_mode_out(v_mode[i]),
            .rise_out(v_rise[i]),
            .fall_out(v_fall[i])
        );

        // Write first, then hardware; hardware events win a same-cycle write
        always_comb begin
            ctrl_nxt[i] = ctrl_r[i];
            if (reg_write_in && reg_addr_in == ADDRS[i]) begin
                ctrl_nxt[i] = reg_wdata_in & MASKS[i];
            end
            if (!en_mode[i] && seq_go_active_in) begin
                ctrl_nxt[i][rgc_pkg::BIT_ENABLE] = ctrl_r[i][TGT[i]];
            end
            if (!en_mode[i] && seq_go_passive_in) begin
                ctrl_nxt[i][rgc_pkg::BIT_ENABLE] = 1'b0;
            end
            if (en_rise[i]) begin
                ctrl_nxt[i][rgc_pkg::BIT_ENABLE] = 1'b1;
            end
            if (en_fall[i]) begin
                ctrl_nxt[i][rgc_pkg::BIT_ENABLE] = 1'b0;
            end
        end

        always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                ctrl_r[i] <= RSTS[i];
            end else begin
                ctrl_r[i] <= ctrl_nxt[i];
            end
        end

        // Voltage slot: B after going passive, A after going active
        always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                vsel_b_r[i] <= 1'b0;
            end else if (v_rise[i]) begin
                vsel_b_r[i] <= 1'b0;
            end else if (v_fall[i]) begin
                vsel_b_r[i] <= 1'b1;
            end else if (!v_mode[i] && seq_go_active_in) begin
                vsel_b_r[i] <= 1'b0;
            end else if (!v_mode[i] && seq_go_passive_in) begin
                vsel_b_r[i] <= 1'b1;
            end
        end
    end

    // Switch close bit is software-only; its target bit is stored, not acted on

    // ==========================================
    // Read port: data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_read_in) begin
            if (reg_addr_in == ADDRS[0]) begin
                reg_rdata_out <= ctrl_r[0];
            end else if (reg_addr_in == ADDRS[1]) begin
                reg_rdata_out <= ctrl_r[1];
            end else if (reg_addr_in == ADDRS[2]) begin
                reg_rdata_out <= ctrl_r[2];
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // ==========================================
    // Outputs, registered: they trail the register bits by one cycle
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            io_buck_enable_out <= 1'b0;
            io_buck_voltage_b_out <= 1'b0;
            peripheral_buck_enable_out <= 1'b0;
            peripheral_buck_voltage_b_out <= 1'b0;
            peripheral_switch_close_out <= 1'b0;
            linear_reg_first_enable_out <= 1'b0;
            linear_reg_first_voltage_b_out <= 1'b0;
            linear_reg_first_pulldown_on_out <= 1'b1;
        end else begin
            io_buck_enable_out <= ctrl_r[0][rgc_pkg::BIT_ENABLE];
            io_buck_voltage_b_out <= vsel_b_r[0];
            peripheral_buck_enable_out <= ctrl_r[1][rgc_pkg::BIT_ENABLE];
            peripheral_buck_voltage_b_out <= vsel_b_r[1];
            peripheral_switch_close_out <= ctrl_r[1][rgc_pkg::BIT_SWITCH_CLOSE];
            linear_reg_first_enable_out <= ctrl_r[2][rgc_pkg::BIT_ENABLE];
            linear_reg_first_voltage_b_out <= vsel_b_r[2];
            // Pull-down only matters while disabled
            linear_reg_first_pulldown_on_out <= !ctrl_r[2][rgc_pkg::BIT_ENABLE]
                && !ctrl_r[2][rgc_pkg::BIT_PULLDOWN_OFF];
        end
    end
endmodule : rgc_regs

/* File: rgc_pkg.sv */
// Package for the regulator control register bank
// Assumes 8-bit registers on a plain strobe port, one clock domain
package rgc_pkg;
    // ==========================================
    // Register offsets
    localparam logic [7:0] ADDR_IO_BUCK_CONTROL = 8'h24;
    localparam logic [7:0] ADDR_PERIPHERAL_BUCK_CONTROL = 8'h25;
    localparam logic [7:0] ADDR_LINEAR_REG_FIRST_CONTROL = 8'h26;
    // ==========================================
    // Reset values
    localparam logic [7:0] RST_IO_BUCK_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIPHERAL_BUCK_CONTROL = 8'h00;
    localparam logic [7:0] RST_LINEAR_REG_FIRST_CONTROL = 8'h00;
    // ==========================================
    // Field positions
    localparam int BIT_ENABLE = 0;
    localparam int FLD_EN_SEL_LO = 1;
    localparam int FLD_EN_SEL_HI = 2;
    localparam int BIT_BUCK_TARGET = 3;
    localparam int BIT_PULLDOWN_OFF = 3;
    localparam int BIT_SWITCH_CLOSE = 4;
    localparam int FLD_V_SEL_LO = 5;
    localparam int FLD_V_SEL_HI = 6;
    localparam int BIT_SW_TARGET = 7;
    localparam int BIT_LDO_TARGET = 7;
    // Writable masks: reserved bits read zero
    localparam logic [7:0] MASK_IO_BUCK = 8'h6f;
    localparam logic [7:0] MASK_PERIPHERAL_BUCK = 8'hff;
    localparam logic [7:0] MASK_LINEAR_REG_FIRST = 8'hef;
    // ==========================================
    // Pin select codes
    localparam logic [1:0] SEL_SEQUENCER = 2'h0;
    localparam logic [1:0] SEL_INPUT_ONE = 2'h1;
    localparam logic [1:0] SEL_INPUT_TWO = 2'h2;
    localparam logic [1:0] SEL_INPUT_THIRTEEN = 2'h3;
endpackage : rgc_pkg

/* File: rgc_pin_select.sv */
// Pin-control field decoder and edge detector for one function
// Assumes the three input pins are synchronous to the clock
`timescale 1ns/1ps
module rgc_pin_select (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Field and pins
    input wire logic [1:0] sel_in,
    input wire logic pin_one_in,
    input wire logic pin_two_in,
    input wire logic pin_thirteen_in,
    // Results
    output logic pin_mode_out,
    output logic rise_out,
    output logic fall_out
);
    logic level;
    logic level_r;

    // ==========================================
    // Decode
    always_comb begin
        unique case (sel_in)
            rgc_pkg::SEL_SEQUENCER: level = 1'b0;
            rgc_pkg::SEL_INPUT_ONE: level = pin_one_in;
            rgc_pkg::SEL_INPUT_TWO: level = pin_two_in;
            rgc_pkg::SEL_INPUT_THIRTEEN: level = pin_thirteen_in;
        endcase
    end

    assign pin_mode_out = (sel_in != rgc_pkg::SEL_SEQUENCER);

    // Previous level; a field change can look like an edge, accepted
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            level_r <= 1'b0;
        end else begin
            level_r <= level;
        end
    end

    assign rise_out = pin_mode_out && level && !level_r;
    assign fall_out = pin_mode_out && !level && level_r;
endmodule : rgc_pin_select

/* File: rgc_regs_asserts.sv */
// Checker for the regulator control register bank
// Assumes it is bound onto rgc_regs and sees only its ports
`timescale 1ns/1ps
module rgc_regs_asserts (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    // Sequencer and pins
    input wire logic seq_go_active_in,
    input wire logic seq_go_passive_in,
    input wire logic pin_one_in,
    input wire logic pin_two_in,
    input wire logic pin_thirteen_in,
    // Regulator controls
    input wire logic io_buck_enable_out,
    input wire logic io_buck_voltage_b_out,
    input wire logic peripheral_switch_close_out,
    input wire logic linear_reg_first_pulldown_on_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic [7:0] io_shadow_r;
    logic quiet;
    logic pins_low;
    logic pins_low_r;
    // Pin edges also override bit 0: pins low now and one edge ago
    assign pins_low = !pin_one_in && !pin_two_in && !pin_thirteen_in;
    assign quiet = !seq_go_active_in && !seq_go_passive_in && pins_low && pins_low_r;
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pins_low_r <= 1'b1;
        end else begin
            pins_low_r <= pins_low;
        end
    end
    // Software copy only; events never touch fields or targets
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            io_shadow_r <= 8'h00;
        end else if (reg_write_in && reg_addr_in == 8'h24) begin
            io_shadow_r <= reg_wdata_in;
        end
    end
    sequence wr_peri; reg_write_in && quiet && reg_addr_in == 8'h25; endsequence
    sequence rd_peri; reg_read_in && reg_addr_in == 8'h25; endsequence
    // Events win over writes, so writes are judged only when quiet, except the switch bit write, which events never touch
    a_read_idle: assert property (
        !$past(reg_read_in) |-> reg_rdata_out == 8'h00) else $error("read data outside slot");
    a_read_back: assert property (
        wr_peri ##1 rd_peri |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("readback differs");
    a_unmapped_zero: assert property (
        reg_read_in && (reg_addr_in < 8'h24 || reg_addr_in > 8'h26) |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_write_enable: assert property (
        reg_write_in && quiet && reg_addr_in == 8'h24
        |-> ##2 io_buck_enable_out == $past(reg_wdata_in[0], 2)) else $error("enable write lost");
    a_switch_write: assert property (
        reg_write_in && reg_addr_in == 8'h25
        |-> ##2 peripheral_switch_close_out == $past(reg_wdata_in[4], 2)) else $error("switch");
    a_pulldown_ctl: assert property (
        reg_write_in && quiet && reg_addr_in == 8'h26 |-> ##2 linear_reg_first_pulldown_on_out
        == !($past(reg_wdata_in[0], 2) || $past(reg_wdata_in[3], 2))) else $error("pulldown");
    a_seq_active: assert property (
        seq_go_active_in && !reg_write_in && io_shadow_r[6:5] == 2'h0 && io_shadow_r[2:1] == 2'h0
        |-> ##2 io_buck_enable_out == $past(io_shadow_r[3], 2) && !io_buck_voltage_b_out)
        else $error("go active copy wrong");
    a_seq_passive: assert property (
        seq_go_passive_in && !reg_write_in && io_shadow_r[6:5] == 2'h0 && io_shadow_r[2:1] == 2'h0
        |-> ##2 !io_buck_enable_out && io_buck_voltage_b_out) else $error("go passive wrong");
    a_pin_rise: assert property (
        io_shadow_r[2:1] == 2'h1 && $rose(pin_one_in) |-> ##[1:3] io_buck_enable_out)
        else $error("pin rise did not enable");
endmodule : rgc_regs_asserts

bind rgc_regs rgc_regs_asserts u_chk (.ref_clk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in,
    .reg_write_in, .reg_read_in, .reg_rdata_out, .seq_go_active_in, .seq_go_passive_in,
    .pin_one_in, .pin_two_in, .pin_thirteen_in, .io_buck_enable_out,
    .io_buck_voltage_b_out, .peripheral_switch_close_out,
    .linear_reg_first_pulldown_on_out);

/* File: rgc_regs_tb.sv */
// Self-checking bench for the regulator control register bank
// Assumes rgc_regs with its checker bound; pins change only on clock edges
`timescale 1ns/1ps
module rgc_regs_tb;
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic go_act = 1'b0;
    logic go_pas = 1'b0;
    logic [2:0] pins = 3'h0;
    wire [7:0] rdata;
    wire [7:0] ctl;
    int mismatches = 0;
    int comparisons = 0;
    always #10 ref_clk_in = ~ref_clk_in;
    rgc_regs DUT (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
        .reg_rdata_out(rdata), .seq_go_active_in(go_act), .seq_go_passive_in(go_pas),
        .pin_one_in(pins[0]), .pin_two_in(pins[1]), .pin_thirteen_in(pins[2]),
        .io_buck_enable_out(ctl[7]), .io_buck_voltage_b_out(ctl[6]),
        .peripheral_buck_enable_out(ctl[5]), .peripheral_buck_voltage_b_out(ctl[4]),
        .peripheral_switch_close_out(ctl[3]), .linear_reg_first_enable_out(ctl[2]),
        .linear_reg_first_voltage_b_out(ctl[1]), .linear_reg_first_pulldown_on_out(ctl[0]));
    // ==========================================
    // Shared tasks
    task automatic end_sim;
        $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Optional write, then a read straight behind it
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] exp);
        if (w) begin
            @(posedge ref_clk_in);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
        end
        @(posedge ref_clk_in);
        wr <= 1'b0;
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        @(negedge ref_clk_in);
        chk("read data", exp, rdata);
    endtask : acc
    task automatic idle;
        repeat (4) @(negedge ref_clk_in);
    endtask : idle
    task automatic pulse(input logic act);
        @(posedge ref_clk_in);
        go_act <= act;
        go_pas <= !act;
        @(posedge ref_clk_in);
        go_act <= 1'b0;
        go_pas <= 1'b0;
        idle();
    endtask : pulse
    // ==========================================
    // Scenarios
    task automatic t_reset;
        for (int a = 8'h24; a <= 8'h26; a++) acc(1'b0, a[7:0], 8'h00, 8'h00);
        chk("controls", 8'h01, ctl);
    endtask : t_reset
    task automatic t_fields;
        acc(1'b1, 8'h24, 8'hff, 8'h6f);
        acc(1'b1, 8'h25, 8'hff, 8'hff);
        acc(1'b1, 8'h26, 8'hff, 8'hef);
        acc(1'b1, 8'h27, 8'hff, 8'h00);
        idle();
        chk("controls", 8'hac, ctl);
        acc(1'b1, 8'h26, 8'h08, 8'h08);
        idle();
        chk("controls", 8'ha8, ctl);
        acc(1'b1, 8'h25, 8'h00, 8'h00);
        acc(1'b1, 8'h26, 8'h00, 8'h00);
    endtask : t_fields
    task automatic t_seq;
        acc(1'b1, 8'h24, 8'h08, 8'h08);
        acc(1'b1, 8'h26, 8'h80, 8'h80);
        pulse(1'b1);
        chk("controls", 8'h84, ctl);
        pulse(1'b0);
        chk("controls", 8'h53, ctl);
    endtask : t_seq
    // Pins stay low while fields change, so no stray edge appears
    task automatic t_pins;
        logic [7:0] d;
        for (int i = 1; i <= 3; i++) begin
            d = {1'b0, i[1:0], 2'b00, i[1:0], 1'b0};
            for (int a = 8'h24; a <= 8'h26; a++) acc(1'b1, a[7:0], d, d);
            @(posedge ref_clk_in);
            pins[i-1] <= 1'b1;
            idle();
            chk("controls", 8'ha4, ctl);
            @(posedge ref_clk_in);
            pins <= 3'h0;
            idle();
            chk("controls", 8'h53, ctl);
        end
    endtask : t_pins
    initial begin
        repeat (16) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_fields();
        t_seq();
        t_pins();
        end_sim();
    end
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
endmodule : rgc_regs_tb
